/* sim/gauge_alert_chk.sv */
// Port-level assertions for the gauge alert block
`timescale 1ns/1ps
module gauge_alert_chk (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Serial pins
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  // Alert causes
  input wire logic meas_valid_i,
  input wire logic insert_cmp_i,
  input wire logic remove_cmp_i,
  // Alert pin
  input wire logic alert_out_n_o,
  input wire logic alert_out_n_oe_o
);
  logic scl_d;
  logic [1:0] cmp_d;
  logic [3:0] evt_age;
  logic [3:0] cmp_age;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);
  // Age of last bus clock fall or measurement, and of last detect change
  always_ff @(posedge sys_clk_i) begin
    scl_d <= scl_i;
    cmp_d <= {insert_cmp_i, remove_cmp_i};
    if (!resetn_i) begin
      evt_age <= 4'hf;
      cmp_age <= 4'hf;
    end else begin
      evt_age <= (scl_d && !scl_i) || meas_valid_i ? 4'h0 : evt_age + {3'h0, evt_age != 4'hf};
      cmp_age <= cmp_d != {insert_cmp_i, remove_cmp_i} ? 4'h0 : cmp_age + {3'h0, cmp_age != 4'hf};
    end
  end
  // ==========================================================
  // Assertions
  chk_sda_open_drain: assert property (sda_o == 1'b0)
    else $error("data line level driven high");
  chk_alert_pair: assert property (alert_out_n_oe_o == !alert_out_n_o)
    else $error("alert level and enable disagree");
  chk_reset_released: assert property ($rose(resetn_i) |-> !alert_out_n_oe_o [*8])
    else $error("alert pin active after reset");
  chk_alert_rise_cause: assert property (
    $rose(alert_out_n_oe_o) |-> evt_age < 4'h8 || cmp_age < 4'h8)
    else $error("alert raised without a cause");
  chk_alert_fall_cause: assert property (
    $fell(alert_out_n_oe_o) |-> evt_age < 4'h8)
    else $error("alert released without a clear or update");
  chk_alert_steady: assert property (
    evt_age == 4'hf && cmp_age == 4'hf |-> $stable(alert_out_n_oe_o))
    else $error("alert pin moved while idle");
  chk_sda_bus_only: assert property ($rose(sda_oe_o) |-> evt_age < 4'h8)
    else $error("data line pulled outside a bus cycle");
  chk_ack_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data line changed while bus clock high");
endmodule
bind fuel_gauge_alert_logic gauge_alert_chk i_gauge_alert_chk (
  .sys_clk_i, .resetn_i, .scl_i, .sda_o, .sda_oe_o, .meas_valid_i,
  .insert_cmp_i, .remove_cmp_i, .alert_out_n_o, .alert_out_n_oe_o
);

/* sim/gauge_host_model.sv */
// Host two-wire master model for reading and writing gauge registers
`timescale 1ns/1ps
`include "gauge_alert_consts.svh"
module gauge_host_model (
  // Clock
  input wire logic sys_clk_i,
  // Bus: wire level in, drive out (1 = released)
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  localparam logic [7:0] ADDR_W = {`DEV_ADDR_DEF, 1'b0};
  // Bus idles released
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  // One bit: change data while clock low, sample mid-high
  task automatic xbit(input logic b, output logic r);
    sda_o = b;
    tick(5);
    scl_o = 1'b1;
    tick(5);
    r = sda_i;
    tick(5);
    scl_o = 1'b0;
    tick(5);
  endtask
  task automatic start();
    sda_o = 1'b1;
    tick(5);
    scl_o = 1'b1;
    tick(5);
    sda_o = 1'b0;
    tick(5);
    scl_o = 1'b0;
    tick(5);
  endtask
  task automatic stop();
    sda_o = 1'b0;
    tick(5);
    scl_o = 1'b1;
    tick(5);
    sda_o = 1'b1;
    tick(5);
  endtask
  task automatic wbyte(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) xbit(d[i], r);
    xbit(1'b1, r);
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(1'b1, r);
      d[i] = r;
    end
    xbit(last, r);
  endtask
  // Word write: low byte first
  task automatic write_word(input logic [7:0] a, input logic [15:0] d);
    start();
    wbyte(ADDR_W);
    wbyte(a);
    wbyte(d[7:0]);
    wbyte(d[15:8]);
    stop();
  endtask
  // Word read through repeated start, NACK after high byte
  task automatic read_word(input logic [7:0] a, output logic [15:0] d);
    start();
    wbyte(ADDR_W);
    wbyte(a);
    start();
    wbyte(ADDR_W | 8'h01);
    rbyte(1'b0, d[7:0]);
    rbyte(1'b1, d[15:8]);
    stop();
  endtask
endmodule

/* sim/testbench.sv */
// Self-checking bench for the gauge alert block
`timescale 1ns/1ps
`include "gauge_alert_consts.svh"
module testbench;
  localparam logic [127:0] SER = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0; // Arbitrary
  localparam logic [127:0] DYN = 128'h7777666655554444333322221111abcd;
  localparam logic [63:0] DYN_OFS = 64'hdfdedddcdad9d5d4;
  localparam logic [31:0] LIM_OFS = 32'hb4030201;
  localparam logic [63:0] RST = {`RST_ILIM, `RST_SLIM, `RST_TLIM, `RST_VLIM};
  localparam logic [63:0] LIM = 64'h0afe50141ef69060;
  localparam logic [15:0] NV = 16'h8000;
  localparam logic [15:0] NC = 16'hff00;
  localparam logic [15:0] NT = 16'hfb00;
  localparam logic [15:0] NS = 16'h3200;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic meas_valid = 1'b0;
  logic [15:0] volt = NV;
  logic [15:0] curr = NC;
  logic [15:0] die = NT;
  logic [15:0] soc = NS;
  logic insert_cmp = 1'b0;
  logic remove_cmp = 1'b0;
  logic scl;
  logic host_sda;
  logic sda_oe;
  logic alert_oe;
  logic [15:0] rdat;
  int mismatches = 0;
  int tests_run = 0;
  // Pull-ups on data and alert lines
  wire sda_w = host_sda & ~sda_oe;
  wire [15:0] alert_w = {15'h0, ~alert_oe};
  always #5 sys_clk = ~sys_clk;
  fuel_gauge_alert_logic #(.SERIAL(SER)) i_fuel_gauge_alert_logic (
    .sys_clk_i(sys_clk), .resetn_i(resetn), .scl_i(scl), .sda_i(sda_w), .sda_o(),
    .sda_oe_o(sda_oe), .meas_valid_i(meas_valid), .cell_voltage_reading_i(volt),
    .current_i(curr), .chip_core_heat_i(die), .thermistor_temp_i(16'h2200),
    .reported_charge_pct_i(soc), .dyn_words_i(DYN), .insert_cmp_i(insert_cmp),
    .remove_cmp_i(remove_cmp), .alert_out_n_o(), .alert_out_n_oe_o(alert_oe));
  gauge_host_model host (.sys_clk_i(sys_clk), .sda_i(sda_w), .scl_o(scl), .sda_o(host_sda));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    host.write_word(a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    host.read_word(a, rdat);
    check(rdat, e);
  endtask
  // One measurement pulse with all readings
  task automatic meas(input logic [15:0] v, c, t, s);
    {volt, curr, die, soc} = {v, c, t, s};
    meas_valid = 1'b1;
    @(posedge sys_clk);
    #1;
    meas_valid = 1'b0;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic pin(input logic e);
    repeat (10) @(posedge sys_clk);
    #1;
    check(alert_w, {15'h0, e});
  endtask
  task automatic complete_run();
    if (mismatches == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (60000) @(posedge sys_clk);
    mismatches++;
    complete_run();
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (2) @(posedge sys_clk);
    #1;
    resetn = 1'b1;
    pin(1'b1);
    for (int k = 0; k < 4; k++) rd(LIM_OFS[8*k+:8], RST[16*k+:16]);
    meas(NV, NC, NT, NS);
    meas(NV, NC, NT, NS);
    rd(`OFS_DIE, NT);
    rd(`OFS_TEMP, NT);
    wr(`OFS_CFG, 16'h8000);
    rd(`OFS_TEMP, 16'h2200);
    rd(`OFS_PWR, 16'hff80);
    rd(`OFS_AVGP, 16'hffe2);
    wr(`OFS_PWR, 16'h1234);
    rd(`OFS_PWR, 16'hff80);
    rd(8'h40, 16'h0000);
    for (int k = 0; k < 4; k++) wr(LIM_OFS[8*k+:8], LIM[16*k+:16]);
    for (int k = 0; k < 4; k++) rd(LIM_OFS[8*k+:8], LIM[16*k+:16]);
    wr(`OFS_CFG, 16'h0004);
    pin(1'b1);
    for (int k = 0; k < 4; k++) begin
      meas(k == 0 ? 16'h9100 : NV, k == 3 ? 16'h0b00 : NC,
           k == 1 ? 16'h1f00 : NT, k == 2 ? 16'h1300 : NS);
      pin(1'b0);
      meas(NV, NC, NT, NS);
      pin(1'b1);
    end
    meas(16'h90ff, NC, NT, NS);
    pin(1'b1);
    wr(`OFS_CFG, 16'h1004);
    meas(16'h5f00, NC, NT, NS);
    meas(NV, NC, NT, NS);
    pin(1'b0);
    wr(`OFS_STATUS, 16'h0000);
    pin(1'b1);
    wr(`OFS_CFG2, 16'h3080);
    pin(1'b1);
    meas(NV, NC, NT, 16'h3380);
    meas(NV, NC, NT, 16'h3380);
    pin(1'b0);
    wr(`OFS_STATUS, 16'h0000);
    meas(NV, NC, NT, 16'h33c0);
    pin(1'b1);
    for (int j = 0; j < 2; j++) begin
      wr(`OFS_CFG2, j ? 16'h3000 : 16'h0000);
      for (int k = 0; k < 8; k++) begin
        rd(DYN_OFS[8*k+:8], j ? DYN[16*k+:16] : SER[16*k+:16]);
      end
    end
    wr(`OFS_CFG, 16'h0007);
    pin(1'b1);
    for (int k = 0; k < 2; k++) begin
      {insert_cmp, remove_cmp} = k ? 2'b10 : 2'b01;
      pin(1'b0);
      {insert_cmp, remove_cmp} = 2'b00;
      pin(1'b0);
      wr(`OFS_STATUS, 16'h0000);
      pin(1'b1);
    end
    complete_run();
  end
endmodule

/* verilog/fuel_gauge_alert_logic.sv */
// Alert generation, power reports and serial-number overlay of a battery gauge
//
// Contract
// [RULE1] Die temperature always reported; main temperature equals it when source select is 0.
// [RULE2] Instant power is current times voltage, scaled to 1.6mW per bit.
// [RULE3] Average power is a filtered mean of instant power, same scale.
// [RULE4] All alerts share one open-drain alert output with external pull-up.
// [RULE5] Removal comparison true with removal detect enabled raises an alert.
// [RULE6] Insertion comparison true with insertion detect enabled raises an alert.
// [RULE7] With threshold alerts enabled, any reading outside its limits raises an alert.
// [RULE8] With step alerts enabled, a change of charge bit d8 raises an alert.
// [RULE9] Host programs all limits before enabling threshold alerts.
// [RULE10] Insertion and removal alerts hold until host clears their status flag.
// [RULE11] Threshold alerts either latch or clear once the reading is back inside.
// [RULE12] Limit pair holds maximum in upper byte, minimum in lower byte.
// [RULE13] Voltage limits have 20mV steps; reset value ff00 disables them.
// [RULE14] Temperature limits are signed with 1 degree steps; reset 7f80 disables.
// [RULE15] Charge limits compare at 1% steps; reset ff00 disables them.
// [RULE16] Current limits are signed, sense-dependent steps; reset 7f80 disables them.
// [RULE17] Both prediction enables cleared places a 128-bit serial number in outputs.
// [RULE18] Host sets both enables again to resume normal prediction outputs.
// [RULE19] Serial words appear in order at d4, d5, d9, da, dc, dd, de, df.
// [RULE20] Step flag sets on each integer percent crossing, held until host clears.
// [RULE21] Alert pin pulled low while any enabled alert pends, released otherwise.
// [RULE22] Threshold comparisons are re-evaluated on every measurement update.
`timescale 1ns/1ps
`include "gauge_alert_consts.svh"
module fuel_gauge_alert_logic
  import gauge_alert_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = `DEV_ADDR_DEF, // Arbitrary value
  parameter logic [127:0] SERIAL = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210, // Arbitrary
  parameter int PWR_SHIFT = `PWR_SHIFT_DEF,
  parameter int AVG_SHIFT = `AVG_SHIFT_DEF
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Serial register port pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Measurement front end (same clock)
  input wire logic meas_valid_i,
  input wire logic [15:0] cell_voltage_reading_i,
  input wire logic [15:0] current_i,
  input wire logic [15:0] chip_core_heat_i,
  input wire logic [15:0] thermistor_temp_i,
  input wire logic [15:0] reported_charge_pct_i,
  // Dynamic power and rate prediction words, index 0 to 7
  input wire logic [127:0] dyn_words_i,
  // Battery detect comparators (asynchronous)
  input wire logic insert_cmp_i,
  input wire logic remove_cmp_i,
  // Alert pin
  output logic alert_out_n_o,
  output logic alert_out_n_oe_o
);

  gauge_regs_t s;
  gauge_regs_t n;
  logic [7:0] rd_addr;
  logic [15:0] rdata;
  logic wr_stb;
  logic [7:0] wr_addr;
  logic [15:0] wr_data;
  logic [3:0] over;
  logic [3:0] under;
  logic [3:0] sticky;
  logic [15:0] temp_rep;
  logic serial_mode;
  logic signed [32:0] prod;
  logic signed [32:0] pwr_full;
  logic signed [16:0] avg_diff;

  // Channel order: voltage, temperature, charge, current
  localparam int OVER_BIT [4] = '{`ST_VMX, `ST_TMX, `ST_SMX, `ST_IMX};
  localparam int UNDER_BIT [4] = '{`ST_VMN, `ST_TMN, `ST_SMN, `ST_IMN};

  // ==========================================================
  // Serial register port
  i2c_reg_port #(
    .DEV_ADDR(DEV_ADDR)
  ) u_port (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_oe_o(sda_oe_o),
    .rd_addr_o(rd_addr),
    .rdata_i(rdata),
    .wr_stb_o(wr_stb),
    .wr_addr_o(wr_addr),
    .wr_data_o(wr_data)
  );

  // ==========================================================
  // Threshold windows; voltage and charge unsigned, others signed
  limit_check #(
    .CH(4)
  ) u_limits (
    .rd_hi_i({s.curr[15:8], s.soc[15:8], temp_rep[15:8], s.volt[15:8]}),
    .lim_i({s.ilim, s.slim, s.tlim, s.vlim}),
    .sgn_i(4'b1010), // [RULE14] [RULE16]
    .over_o(over),
    .under_o(under)
  );

  // Main temperature follows the source select
  assign temp_rep = s.cfg[`CFG_HEAT_SOURCE_SELECT] ? s.therm : s.die; // [RULE1]
  assign sticky = {s.cfg[`CFG_IS], s.cfg[`CFG_SS], s.cfg[`CFG_TS], s.cfg[`CFG_VS]};
  assign serial_mode = ~s.cfg2[`CFG2_RATE_PREDICT_EN] & ~s.cfg2[`CFG2_DYN_POWER_EN]; // [RULE17] [RULE18]

  // ==========================================================
  // Power arithmetic on the incoming readings
  assign prod = $signed(current_i) * $signed({1'b0, cell_voltage_reading_i});
  assign pwr_full = prod >>> PWR_SHIFT; // [RULE2]
  assign avg_diff = $signed({s.power[15], s.power}) - $signed({s.avgpwr[15], s.avgpwr});

  // ==========================================================
  // Register read multiplexer; unmapped offsets read zero
  always_comb begin
    rdata = `RST_WORD;
    case (rd_addr)
      `OFS_STATUS: rdata = s.status;
      `OFS_VLIM: rdata = s.vlim;
      `OFS_TLIM: rdata = s.tlim;
      `OFS_SLIM: rdata = s.slim;
      `OFS_ILIM: rdata = s.ilim;
      `OFS_SOC: rdata = s.soc;
      `OFS_TEMP: rdata = temp_rep;
      `OFS_CELL_VOLTAGE_READING: rdata = s.volt;
      `OFS_CURR: rdata = s.curr;
      `OFS_CFG: rdata = s.cfg;
      `OFS_CFG2: rdata = s.cfg2;
      `OFS_DIE: rdata = s.die; // [RULE1]
      `OFS_PWR: rdata = s.power;
      `OFS_AVGP: rdata = s.avgpwr;
      // Prediction outputs, replaced by serial words in serial mode
      `OFS_DYN0: rdata = serial_mode ? SERIAL[15:0] : dyn_words_i[15:0]; // [RULE19]
      `OFS_DYN1: rdata = serial_mode ? SERIAL[31:16] : dyn_words_i[31:16];
      `OFS_DYN2: rdata = serial_mode ? SERIAL[47:32] : dyn_words_i[47:32];
      `OFS_DYN3: rdata = serial_mode ? SERIAL[63:48] : dyn_words_i[63:48];
      `OFS_DYN4: rdata = serial_mode ? SERIAL[79:64] : dyn_words_i[79:64];
      `OFS_DYN5: rdata = serial_mode ? SERIAL[95:80] : dyn_words_i[95:80];
      `OFS_DYN6: rdata = serial_mode ? SERIAL[111:96] : dyn_words_i[111:96];
      `OFS_DYN7: rdata = serial_mode ? SERIAL[127:112] : dyn_words_i[127:112];
      default: rdata = `RST_WORD;
    endcase
  end

  // ==========================================================
  // Next state: readings, register writes, flags and alert pin
  always_comb begin
    n = s;
    // Detect comparators pass two flip-flops before use
    n.ins_s = {s.ins_s[1:0], insert_cmp_i};
    n.rem_s = {s.rem_s[1:0], remove_cmp_i};
    n.eval = meas_valid_i;

    // Capture readings and update power reports
    if (meas_valid_i) begin
      n.volt = cell_voltage_reading_i;
      n.curr = current_i;
      n.die = chip_core_heat_i;
      n.therm = thermistor_temp_i;
      n.soc = reported_charge_pct_i;
      n.power = pwr_full[15:0]; // [RULE2]
    end
    // Average moves toward the newly captured instant value one clock after each update
    if (s.eval) begin
      n.avgpwr = s.avgpwr + 16'(avg_diff >>> AVG_SHIFT); // [RULE3]
    end

    // Register writes from the host
    if (wr_stb) begin
      case (wr_addr)
        `OFS_VLIM: n.vlim = wr_data; // [RULE13]
        `OFS_TLIM: n.tlim = wr_data;
        `OFS_SLIM: n.slim = wr_data; // [RULE15]
        `OFS_ILIM: n.ilim = wr_data;
        `OFS_CFG: n.cfg = wr_data;
        `OFS_CFG2: n.cfg2 = wr_data; // [RULE18]
        default: begin
        end
      endcase
    end

    // Auto-clearing threshold flags drop once back inside the window
    if (s.eval) begin
      for (int c = 0; c < 4; c++) begin
        if (!sticky[c]) begin
          n.status[OVER_BIT[c]] = s.status[OVER_BIT[c]] & over[c]; // [RULE11]
          n.status[UNDER_BIT[c]] = s.status[UNDER_BIT[c]] & under[c]; // [RULE11]
        end
      end
    end
    // Host write to status, then hardware sets win over the clear
    if (wr_stb && wr_addr == `OFS_STATUS) begin
      n.status = wr_data; // [RULE10]
    end
    if (s.eval) begin
      for (int c = 0; c < 4; c++) begin
        n.status[OVER_BIT[c]] = n.status[OVER_BIT[c]] | over[c]; // [RULE22]
        n.status[UNDER_BIT[c]] = n.status[UNDER_BIT[c]] | under[c]; // [RULE22]
      end
    end
    if (meas_valid_i && reported_charge_pct_i[`SOC_STEP_BIT] != s.soc[`SOC_STEP_BIT]) begin
      n.status[`ST_CHARGE_STEP_FLAG] = 1'b1; // [RULE20]
    end
    // Detect events fire on the rising edge of each comparison
    if (s.ins_s[1] && !s.ins_s[2]) begin
      n.status[`ST_BI] = 1'b1; // [RULE6]
    end
    if (s.rem_s[1] && !s.rem_s[2]) begin
      n.status[`ST_BR] = 1'b1; // [RULE5]
    end
    n.status[`ST_BST] = s.rem_s[2];

    // Pull the pin low while any enabled alert pends
    n.alert_oe = (s.cfg[`CFG_AEN] & (|{n.status[`ST_VMX], n.status[`ST_VMN],
                  n.status[`ST_TMX], n.status[`ST_TMN], n.status[`ST_SMX],
                  n.status[`ST_SMN], n.status[`ST_IMX], n.status[`ST_IMN]})) // [RULE7]
                 | (s.cfg[`CFG_BER] & n.status[`ST_BR]) // [RULE5] [RULE10]
                 | (s.cfg[`CFG_BEI] & n.status[`ST_BI]) // [RULE6] [RULE10]
                 | (s.cfg2[`CFG2_CHARGE_STEP_ALERT_EN] & n.status[`ST_CHARGE_STEP_FLAG]); // [RULE8]
    n.alert_n = ~n.alert_oe; // [RULE4] [RULE21]
    n.sda_lvl = 1'b0;
  end

  // ==========================================================
  // State register
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      s <= '0;
      s.vlim <= `RST_VLIM; // [RULE13]
      s.tlim <= `RST_TLIM; // [RULE14]
      s.slim <= `RST_SLIM; // [RULE15]
      s.ilim <= `RST_ILIM; // [RULE16]
      s.cfg <= `RST_CFG;
      s.cfg2 <= `RST_CFG2;
      s.status <= `RST_STATUS;
      s.alert_n <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // Outputs taken from the state register
  assign alert_out_n_o = s.alert_n;
  assign alert_out_n_oe_o = s.alert_oe;
  assign sda_o = s.sda_lvl;

endmodule

/* verilog/gauge_alert_consts.svh */
// Register offsets, reset values, field positions and scaling for the alert block
`ifndef GAUGE_ALERT_CONSTS_SVH
`define GAUGE_ALERT_CONSTS_SVH

// ==========================================================
// Register offsets (word addresses on the serial link)
`define OFS_STATUS 8'h00
`define OFS_VLIM 8'h01
`define OFS_TLIM 8'h02
`define OFS_SLIM 8'h03
`define OFS_SOC 8'h06
`define OFS_TEMP 8'h08
`define OFS_CELL_VOLTAGE_READING 8'h09
`define OFS_CURR 8'h0a
`define OFS_CFG 8'h1d
`define OFS_DIE 8'h34
`define OFS_PWR 8'hb1
`define OFS_AVGP 8'hb3
`define OFS_ILIM 8'hb4
`define OFS_CFG2 8'hbb
`define OFS_DYN0 8'hd4
`define OFS_DYN1 8'hd5
`define OFS_DYN2 8'hd9
`define OFS_DYN3 8'hda
`define OFS_DYN4 8'hdc
`define OFS_DYN5 8'hdd
`define OFS_DYN6 8'hde
`define OFS_DYN7 8'hdf

// ==========================================================
// Reset values
`define RST_VLIM 16'hff00
`define RST_TLIM 16'h7f80
`define RST_SLIM 16'hff00
`define RST_ILIM 16'h7f80
`define RST_STATUS 16'h8080
`define RST_CFG 16'h0000
`define RST_CFG2 16'h3000
`define RST_WORD 16'h0000

// ==========================================================
// Setup register fields
`define CFG_BER 0
`define CFG_BEI 1
`define CFG_AEN 2
`define CFG_IS 11
`define CFG_VS 12
`define CFG_TS 13
`define CFG_SS 14
`define CFG_HEAT_SOURCE_SELECT 15
`define CFG2_CHARGE_STEP_ALERT_EN 7
`define CFG2_DYN_POWER_EN 12
`define CFG2_RATE_PREDICT_EN 13

// ==========================================================
// Status fields
`define ST_IMN 2
`define ST_BST 3
`define ST_IMX 6
`define ST_CHARGE_STEP_FLAG 7
`define ST_VMN 8
`define ST_TMN 9
`define ST_SMN 10
`define ST_BI 11
`define ST_VMX 12
`define ST_TMX 13
`define ST_SMX 14
`define ST_BR 15

// ==========================================================
// Reading layout, serial port and power scaling
`define SOC_STEP_BIT 8
`define DEV_ADDR_DEF 7'h2a
`define PWR_SHIFT_DEF 16
`define AVG_SHIFT_DEF 3

`endif

/* verilog/gauge_alert_pkg.sv */
// Types shared by the alert block and its serial register port
package gauge_alert_pkg;

  // ==========================================================
  // Serial port sequencer states
  typedef enum logic [8:0] {
    I2C_IDLE = 9'h001,
    I2C_ADDR = 9'h002,
    I2C_ACK_ADDR = 9'h004,
    I2C_PTR = 9'h008,
    I2C_ACK_PTR = 9'h010,
    I2C_WDATA = 9'h020,
    I2C_ACK_WR = 9'h040,
    I2C_RDATA = 9'h080,
    I2C_ACK_RD = 9'h100
  } i2c_state_t;

  // ==========================================================
  // Serial port state
  typedef struct packed {
    i2c_state_t st;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic [7:0] lowbyte;
    logic hi;
    logic rw;
    logic nack;
    logic [15:0] rword;
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic sda_oe;
    logic wr_stb;
    logic [7:0] wr_addr;
    logic [15:0] wr_data;
  } i2c_regs_t;

  // ==========================================================
  // Alert block state
  typedef struct packed {
    logic [15:0] vlim;
    logic [15:0] tlim;
    logic [15:0] slim;
    logic [15:0] ilim;
    logic [15:0] cfg;
    logic [15:0] cfg2;
    logic [15:0] status;
    logic [15:0] volt;
    logic [15:0] curr;
    logic [15:0] die;
    logic [15:0] therm;
    logic [15:0] soc;
    logic [15:0] power;
    logic [15:0] avgpwr;
    logic eval;
    logic [2:0] ins_s;
    logic [2:0] rem_s;
    logic alert_n;
    logic alert_oe;
    logic sda_lvl;
  } gauge_regs_t;

endpackage

/* verilog/i2c_reg_port.sv */
// Two-wire serial slave giving word read and write access to the register file
`timescale 1ns/1ps
`include "gauge_alert_consts.svh"
module i2c_reg_port
  import gauge_alert_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = `DEV_ADDR_DEF // Arbitrary value
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Serial pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_oe_o,
  // Register access
  output logic [7:0] rd_addr_o,
  input wire logic [15:0] rdata_i,
  output logic wr_stb_o,
  output logic [7:0] wr_addr_o,
  output logic [15:0] wr_data_o
);

  i2c_regs_t s;
  i2c_regs_t n;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic [7:0] txb;

  // ==========================================================
  // Bus condition detection on the second synchroniser stage onward
  assign scl_rise = s.scl_s[1] & ~s.scl_s[2];
  assign scl_fall = ~s.scl_s[1] & s.scl_s[2];
  assign start_c = s.scl_s[1] & s.scl_s[2] & ~s.sda_s[1] & s.sda_s[2];
  assign stop_c = s.scl_s[1] & s.scl_s[2] & s.sda_s[1] & ~s.sda_s[2];
  assign txb = s.hi ? s.rword[15:8] : s.rword[7:0];

  // ==========================================================
  // Next state: bit shifting, acknowledge and low-byte-first words
  always_comb begin
    n = s;
    n.wr_stb = 1'b0;
    n.scl_s = {s.scl_s[1:0], scl_i};
    n.sda_s = {s.sda_s[1:0], sda_i};
    if (start_c) begin
      n.st = I2C_ADDR;
      n.bitcnt = 4'h0;
      n.hi = 1'b0;
      n.sda_oe = 1'b0;
    end else if (stop_c) begin
      n.st = I2C_IDLE;
      n.sda_oe = 1'b0;
    end else if (scl_rise) begin
      case (s.st)
        I2C_ADDR, I2C_PTR, I2C_WDATA: begin
          n.shreg = {s.shreg[6:0], s.sda_s[1]};
          n.bitcnt = s.bitcnt + 4'h1;
        end
        I2C_RDATA: begin
          n.bitcnt = s.bitcnt + 4'h1;
        end
        I2C_ACK_RD: begin
          n.nack = s.sda_s[1];
          // Step the pointer early so the next word is ready at the fall
          if (!s.sda_s[1] && s.hi) begin
            n.ptr = s.ptr + 8'h01;
          end
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (s.st)
        I2C_ADDR: begin
          if (s.bitcnt == 4'h8 && s.shreg[7:1] == DEV_ADDR) begin
            n.sda_oe = 1'b1;
            n.rw = s.shreg[0];
            n.st = I2C_ACK_ADDR;
          end else if (s.bitcnt == 4'h8) begin
            n.st = I2C_IDLE;
          end
        end
        I2C_ACK_ADDR: begin
          n.bitcnt = 4'h0;
          if (s.rw) begin
            n.st = I2C_RDATA;
            n.hi = 1'b0;
            n.rword = rdata_i;
            n.sda_oe = ~rdata_i[7];
          end else begin
            n.st = I2C_PTR;
            n.sda_oe = 1'b0;
          end
        end
        I2C_PTR: begin
          if (s.bitcnt == 4'h8) begin
            n.ptr = s.shreg;
            n.sda_oe = 1'b1;
            n.st = I2C_ACK_PTR;
          end
        end
        I2C_WDATA: begin
          if (s.bitcnt == 4'h8) begin
            n.sda_oe = 1'b1;
            n.st = I2C_ACK_WR;
            n.hi = ~s.hi;
            if (s.hi) begin
              n.wr_stb = 1'b1;
              n.wr_addr = s.ptr;
              n.wr_data = {s.shreg, s.lowbyte};
              n.ptr = s.ptr + 8'h01;
            end else begin
              n.lowbyte = s.shreg;
            end
          end
        end
        I2C_ACK_PTR, I2C_ACK_WR: begin
          n.sda_oe = 1'b0;
          n.bitcnt = 4'h0;
          n.st = I2C_WDATA;
        end
        I2C_RDATA: begin
          if (s.bitcnt == 4'h8) begin
            n.sda_oe = 1'b0;
            n.st = I2C_ACK_RD;
          end else begin
            n.sda_oe = ~txb[3'd7 - s.bitcnt[2:0]];
          end
        end
        I2C_ACK_RD: begin
          n.bitcnt = 4'h0;
          if (s.nack) begin
            n.st = I2C_IDLE;
          end else if (s.hi) begin
            n.st = I2C_RDATA;
            n.hi = 1'b0;
            n.rword = rdata_i;
            n.sda_oe = ~rdata_i[7];
          end else begin
            n.st = I2C_RDATA;
            n.hi = 1'b1;
            n.sda_oe = ~s.rword[15];
          end
        end
        default: begin
          n.st = I2C_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      s <= '0;
      s.st <= I2C_IDLE;
      s.scl_s <= 3'h7;
      s.sda_s <= 3'h7;
    end else begin
      s <= n;
    end
  end

  // Outputs taken from the state register
  assign sda_oe_o = s.sda_oe;
  assign rd_addr_o = s.ptr;
  assign wr_stb_o = s.wr_stb;
  assign wr_addr_o = s.wr_addr;
  assign wr_data_o = s.wr_data;

endmodule

/* verilog/limit_check.sv */
// Min/max window comparison of reading high bytes against limit pairs
`timescale 1ns/1ps
module limit_check #(
  parameter int CH = 4
) (
  // Readings and limits
  input wire logic [CH*8-1:0] rd_hi_i,
  input wire logic [CH*16-1:0] lim_i,
  input wire logic [CH-1:0] sgn_i,
  // Results
  output logic [CH-1:0] over_o,
  output logic [CH-1:0] under_o
);

  // ==========================================================
  // One comparator pair per channel, signed or unsigned by channel
  genvar g;
  generate
    for (g = 0; g < CH; g++) begin : g_ch
      logic [8:0] rd_x;
      logic [8:0] mx_x;
      logic [8:0] mn_x;
      // Extend by sign or zero so a single signed compare serves both kinds
      assign rd_x = {sgn_i[g] & rd_hi_i[g*8+7], rd_hi_i[g*8 +: 8]};
      assign mx_x = {sgn_i[g] & lim_i[g*16+15], lim_i[g*16+8 +: 8]};
      assign mn_x = {sgn_i[g] & lim_i[g*16+7], lim_i[g*16 +: 8]};
      assign over_o[g] = $signed(rd_x) > $signed(mx_x); // [RULE12]
      assign under_o[g] = $signed(rd_x) < $signed(mn_x); // [RULE12]
    end
  endgenerate

endmodule
